// file: inc/cache_pkg.sv
// Constants, types and decode helpers shared by the word cache
// Notes on behaviour
// RQ1 - 512 entries are indexed by word address bits 9 down to 1.
// RQ2 - Address bits 17 down to 10 form the block number kept as tag.
// RQ3 - A fill overwrites whatever tag and data sit at that index.
// RQ4 - Writes go to memory; a cached copy is updated at the same time.
// RQ5 - A read that matches a valid entry raises hit within 150 ns.
// RQ6 - After hit the processor raises control-ok when ready for data.
// RQ7 - After control-ok on a hit, drive read data and data-ready.
// RQ8 - The processor drops control-ok once it has taken the data.
// RQ9 - After control-ok drops, data-ready is removed, ending the cycle.
// RQ10 - Without hit in 150 ns the processor reads memory on the bus.
// RQ11 - A missed read starts writing bus data when slave sync falls.
// RQ12 - The array write command ends when master sync rises.
// RQ13 - Word and byte writes never raise hit, cached or not.
// RQ14 - A bus write to a cached address is copied into that entry.
// RQ15 - The system bus is only listened to, never driven.
// RQ16 - Bus op lines: HH read, LH read-pause, HL write, LL byte write.
// RQ17 - Slave sync means read data valid, or write data accepted.
// RQ18 - The bus initialize input, when low, initializes the cache.
// RQ19 - While supply-low is asserted no array write may occur.
// RQ20 - Selection acknowledge marks the next bus cycle as interrupt.
// RQ21 - Bus-busy is watched to know the bus is owned by a master.
// RQ22 - Fast port: address in, data out, control both ways.
// RQ23 - On init or power-low release, a 9-bit sweep clears all valids.
// RQ24 - Hit only when stored tag equals bits 17:10 and valid is set.
// RQ25 - Fast op lines decode the same four operations as the bus.
// RQ26 - Upper and lower byte of the data array have own strobes.
// RQ27 - A fill writes bits 17:10 into the tag store and sets valid.
// RQ28 - A byte write hit updates only the byte chosen by bit 0.
// RQ29 - Bus strobes are synchronised first, still meeting the deadline.
package cache_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int IDX_W = 9;
   localparam int TAG_W = 8;
   localparam int ENTRIES = 512;
   localparam int IDX_LSB = 1;
   localparam int IDX_MSB = 9;
   localparam int TAG_LSB = 10;
   localparam int TAG_MSB = 17;
   localparam int BYTE_SEL_BIT = 0;
   localparam int LANE_W = 8;
   localparam int LANES = 2;
   localparam int LANE_LOW = 0;
   localparam int LANE_HIGH = 1;
   localparam logic [IDX_W-1:0] IDX_FIRST = 9'h000;
   localparam logic [IDX_W-1:0] IDX_LAST = 9'h1FF;
   localparam logic [IDX_W-1:0] IDX_STEP = 9'h001;

   // Hit deadline; a longest time rounds down to whole cycles
   localparam int HIT_DEADLINE_NS = 150;
   localparam int CLK_PERIOD_NS = 10;
   localparam int HIT_DEADLINE_CYC = HIT_DEADLINE_NS / CLK_PERIOD_NS;

   // Synchroniser vector: one bit per asynchronous control pin
   localparam int CTL_W = 13;
   // Idle levels: strobes high, control-ok low, resets released
   localparam logic [CTL_W-1:0] CTL_IDLE = 13'h1DFF;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      OP_DATI,
      OP_DATIP,
      OP_DATO,
      OP_DATOB
   } op_e;

   // Active-low op lines, shared by both ports
   function automatic op_e op_decode(input logic c0_n, input logic c1_n);
      op_e op;
      op = OP_DATI;
      case ({c0_n, c1_n})
         2'h3: op = OP_DATI;
         2'h1: op = OP_DATIP;
         2'h2: op = OP_DATO;
         default: op = OP_DATOB;
      endcase
      return op;
   endfunction

endpackage

// file: inc/cache_store_if.sv
// Connection between cache control and its tag, valid and data arrays
`timescale 1ns/1ps
interface cache_store_if;
   import cache_pkg::*;

   logic [IDX_W-1:0] rd_idx_a;
   logic [TAG_W-1:0] rd_tag_a;
   logic rd_valid_a;
   logic [DATA_W-1:0] rd_data_a;
   logic [IDX_W-1:0] rd_idx_b;
   logic [TAG_W-1:0] rd_tag_b;
   logic rd_valid_b;
   logic [IDX_W-1:0] wr_idx;
   logic [TAG_W-1:0] wr_tag;
   logic [DATA_W-1:0] wr_data;
   logic tag_we;
   logic upper_byte_wstrobe_n;
   logic lower_byte_wstrobe_n;
   logic clr_en;
   logic [IDX_W-1:0] clr_idx;

   modport ctl (
      output rd_idx_a, rd_idx_b, wr_idx, wr_tag, wr_data, tag_we,
      output upper_byte_wstrobe_n, lower_byte_wstrobe_n, clr_en, clr_idx,
      input rd_tag_a, rd_valid_a, rd_data_a, rd_tag_b, rd_valid_b
   );
   modport mem (
      input rd_idx_a, rd_idx_b, wr_idx, wr_tag, wr_data, tag_we,
      input upper_byte_wstrobe_n, lower_byte_wstrobe_n, clr_en, clr_idx,
      output rd_tag_a, rd_valid_a, rd_data_a, rd_tag_b, rd_valid_b
   );
endinterface

// file: hw/cache_store.sv
// Tag, valid and byte-laned data arrays of the word cache
`timescale 1ns/1ps
module cache_store (
   input wire logic clk_sys,
   cache_store_if.mem sif
);
   import cache_pkg::*;

   logic [TAG_W-1:0] tag_mem [ENTRIES];
   logic [ENTRIES-1:0] valid_reg;
   logic [LANES-1:0] lane_we_n;

   assign lane_we_n = {sif.upper_byte_wstrobe_n, sif.lower_byte_wstrobe_n};

   ////////////////////////////////////////////////////////////////////
   // Tag store; only a fill rewrites it, replacing the old block
   always_ff @(posedge clk_sys) begin
      if (sif.tag_we) begin
         tag_mem[sif.wr_idx] <= sif.wr_tag; // [RQ3] [RQ27]
      end
   end

   // Sweep clear beats a set; fills are held off during a sweep anyway
   always_ff @(posedge clk_sys) begin
      if (sif.clr_en) begin
         valid_reg[sif.clr_idx] <= 1'b0; // [RQ23]
      end else if (sif.tag_we) begin
         valid_reg[sif.wr_idx] <= 1'b1; // [RQ27]
      end
   end

   // Registered reads on both ports
   always_ff @(posedge clk_sys) begin
      sif.rd_tag_a <= tag_mem[sif.rd_idx_a];
      sif.rd_valid_a <= valid_reg[sif.rd_idx_a];
      sif.rd_tag_b <= tag_mem[sif.rd_idx_b];
      sif.rd_valid_b <= valid_reg[sif.rd_idx_b];
   end

   ////////////////////////////////////////////////////////////////////
   // One array per byte lane so each lane has its own write strobe
   for (genvar b = 0; b < LANES; b++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [ENTRIES];
      always_ff @(posedge clk_sys) begin
         if (!lane_we_n[b]) begin
            lane_mem[sif.wr_idx] <= sif.wr_data[b*LANE_W +: LANE_W]; // [RQ26]
         end
         sif.rd_data_a[b*LANE_W +: LANE_W] <= lane_mem[sif.rd_idx_a];
      end
   end

endmodule // cache_store

// file: hw/cache_top.sv
// Direct-mapped write-through word cache: fast read port and bus snoop
`timescale 1ns/1ps
module cache_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [cache_pkg::ADDR_W-1:0] fast_addr,
   input wire logic fast_lookup_n,
   input wire logic fast_op_select0_n,
   input wire logic fast_op_select1_n,
   input wire logic cpu_control_ok,
   output logic cache_hit_n,
   output logic fast_data_ready_n,
   output logic [cache_pkg::DATA_W-1:0] fast_rdata,
   output logic init_active,
   input wire logic [cache_pkg::ADDR_W-1:0] snoop_addr_n,
   input wire logic [cache_pkg::DATA_W-1:0] snoop_wdata_n,
   input wire logic snoop_op_select0_n,
   input wire logic snoop_op_select1_n,
   input wire logic snoop_master_sync_n,
   input wire logic snoop_slave_sync_n,
   input wire logic bus_initialize_n,
   input wire logic supply_low_n,
   input wire logic memory_power_low_n,
   input wire logic select_ack_n,
   input wire logic bus_owner_busy_n
);
   import cache_pkg::*;

   typedef enum logic [2:0] {
      F_IDLE, F_LOOKUP, F_COMPARE, F_WAIT_OK, F_SEND, F_RELEASE
   } fast_state_e;
   typedef enum logic [1:0] {S_IDLE, S_WRITING, S_WAIT_END} snoop_state_e;

   localparam int HIT_WIN = HIT_DEADLINE_CYC;

   cache_store_if sif ();

   logic [CTL_W-1:0] ctl_raw, ctl_m, ctl_s;
   logic [ADDR_W-1:0] faddr_m, faddr_s, saddr_m, saddr_s;
   logic [DATA_W-1:0] sdata_m, sdata_s;
   logic lookup_n_s, fop0_s, fop1_s, ok_s, msync_n_s, ssync_n_s;
   logic sop0_s, sop1_s, init_n_s, dclo_n_s, mpwr_n_s, sack_n_s, bbsy_n_s;
   logic msync_prev_reg, ssync_prev_reg;
   logic msync_fall, msync_rise, ssync_fall;
   logic hold_init, sweep_active_reg;
   logic [IDX_W-1:0] sweep_idx_reg;
   logic intr_pending_reg, intr_cycle_reg;
   fast_state_e fast_state_reg;
   snoop_state_e snoop_state_reg;
   logic [IDX_W-1:0] fidx_reg, widx_reg;
   logic [TAG_W-1:0] ftag_reg, wtag_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic tag_we_reg, upper_n_reg, lower_n_reg;
   op_e fop, sop;
   logic fast_is_read, fast_req_go, fast_match;
   logic snoop_ok, snoop_hit, fill_go, update_go;
   logic [IDX_W-1:0] sidx;
   logic [TAG_W-1:0] stag;

   ////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for every pin; addresses and data pass the
   // same depth so they stay aligned with their strobes
   assign ctl_raw = {fast_lookup_n, fast_op_select0_n, fast_op_select1_n,
                     cpu_control_ok, snoop_master_sync_n,
                     snoop_slave_sync_n, snoop_op_select0_n,
                     snoop_op_select1_n, bus_initialize_n, supply_low_n,
                     memory_power_low_n, select_ack_n, bus_owner_busy_n};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl_m <= CTL_IDLE;
         ctl_s <= CTL_IDLE;
         faddr_m <= ADDR_ZERO;
         faddr_s <= ADDR_ZERO;
         saddr_m <= ADDR_ZERO;
         saddr_s <= ADDR_ZERO;
         sdata_m <= DATA_ZERO;
         sdata_s <= DATA_ZERO;
      end else begin
         ctl_m <= ctl_raw; // [RQ29]
         ctl_s <= ctl_m;
         faddr_m <= fast_addr;
         faddr_s <= faddr_m;
         saddr_m <= ~snoop_addr_n; // [RQ15]
         saddr_s <= saddr_m;
         sdata_m <= ~snoop_wdata_n;
         sdata_s <= sdata_m;
      end
   end

   assign {lookup_n_s, fop0_s, fop1_s, ok_s, msync_n_s, ssync_n_s, sop0_s,
           sop1_s, init_n_s, dclo_n_s, mpwr_n_s, sack_n_s, bbsy_n_s} = ctl_s;

   // Edge history of the bus strobes, read only after synchronising
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         msync_prev_reg <= 1'b1;
         ssync_prev_reg <= 1'b1;
      end else begin
         msync_prev_reg <= msync_n_s;
         ssync_prev_reg <= ssync_n_s;
      end
   end

   assign msync_fall = msync_prev_reg && !msync_n_s;
   assign msync_rise = !msync_prev_reg && msync_n_s;
   assign ssync_fall = ssync_prev_reg && !ssync_n_s; // [RQ17]

   ////////////////////////////////////////////////////////////////////
   // Invalidation sweep: held at entry 0 while initialize or power-low
   // is asserted, then walks all entries once after release
   assign hold_init = !init_n_s || !mpwr_n_s; // [RQ18]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sweep_active_reg <= 1'b1;
         sweep_idx_reg <= IDX_FIRST;
      end else if (hold_init) begin
         sweep_active_reg <= 1'b1;
         sweep_idx_reg <= IDX_FIRST;
      end else if (sweep_active_reg) begin
         sweep_idx_reg <= sweep_idx_reg + IDX_STEP; // [RQ23]
         if (sweep_idx_reg == IDX_LAST) begin
            sweep_active_reg <= 1'b0;
         end
      end
   end

   assign init_active = sweep_active_reg;
   assign sif.clr_en = sweep_active_reg;
   assign sif.clr_idx = sweep_idx_reg;

   ////////////////////////////////////////////////////////////////////
   // Interrupt cycle marking; an acknowledge in the cycle that starts
   // a bus transfer still counts, so the set wins over the clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         intr_pending_reg <= 1'b0;
      end else if (!sack_n_s) begin
         intr_pending_reg <= 1'b1; // [RQ20]
      end else if (msync_fall) begin
         intr_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         intr_cycle_reg <= 1'b0;
      end else if (msync_fall) begin
         intr_cycle_reg <= intr_pending_reg || !sack_n_s; // [RQ20]
      end else if (msync_rise) begin
         intr_cycle_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fast port lookup path
   assign fop = op_decode(fop0_s, fop1_s); // [RQ25]
   assign fast_is_read = (fop == OP_DATI) || (fop == OP_DATIP); // [RQ13]
   assign fast_req_go = !lookup_n_s && fast_is_read && !sweep_active_reg;
   assign fast_match = sif.rd_valid_a && (sif.rd_tag_a == ftag_reg); // [RQ24]
   assign sif.rd_idx_a = fidx_reg;

   // Hit answer is five edges after the request pin, well inside 150 ns
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fast_state_reg <= F_IDLE;
         fidx_reg <= IDX_FIRST;
         ftag_reg <= '0;
         cache_hit_n <= 1'b1;
         fast_data_ready_n <= 1'b1;
         fast_rdata <= DATA_ZERO;
      end else begin
         case (fast_state_reg)
            F_IDLE: begin
               if (fast_req_go) begin
                  fidx_reg <= faddr_s[IDX_MSB:IDX_LSB]; // [RQ1] [RQ22]
                  ftag_reg <= faddr_s[TAG_MSB:TAG_LSB]; // [RQ2]
                  fast_state_reg <= F_LOOKUP;
               end else if (!lookup_n_s) begin
                  fast_state_reg <= F_RELEASE; // [RQ13]
               end
            end
            F_LOOKUP: fast_state_reg <= F_COMPARE;
            F_COMPARE: begin
               if (fast_match && !lookup_n_s) begin
                  cache_hit_n <= 1'b0; // [RQ5]
                  fast_state_reg <= F_WAIT_OK;
               end else begin
                  fast_state_reg <= F_RELEASE;
               end
            end
            F_WAIT_OK: begin
               if (lookup_n_s) begin
                  cache_hit_n <= 1'b1;
                  fast_state_reg <= F_IDLE;
               end else if (ok_s) begin
                  fast_rdata <= sif.rd_data_a; // [RQ7]
                  fast_data_ready_n <= 1'b0;
                  fast_state_reg <= F_SEND;
               end
            end
            F_SEND: begin
               if (!ok_s) begin
                  fast_data_ready_n <= 1'b1; // [RQ9]
                  cache_hit_n <= 1'b1;
                  fast_state_reg <= F_RELEASE;
               end
            end
            F_RELEASE: begin
               if (lookup_n_s) begin
                  fast_state_reg <= F_IDLE;
               end
            end
            default: fast_state_reg <= F_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bus snoop: fills on reads, write-through updates on cached writes
   assign sop = op_decode(sop0_s, sop1_s); // [RQ16]
   assign sidx = saddr_s[IDX_MSB:IDX_LSB];
   assign stag = saddr_s[TAG_MSB:TAG_LSB];
   assign sif.rd_idx_b = sidx;
   assign snoop_hit = sif.rd_valid_b && (sif.rd_tag_b == stag);
   // Only act for a real memory transfer by an owning master
   assign snoop_ok = !bbsy_n_s && !intr_cycle_reg && !sweep_active_reg &&
                     dclo_n_s && mpwr_n_s && !msync_n_s; // [RQ21] [RQ19]
   assign fill_go = ssync_fall && snoop_ok &&
                    ((sop == OP_DATI) || (sop == OP_DATIP)); // [RQ11]
   assign update_go = ssync_fall && snoop_ok && snoop_hit &&
                      ((sop == OP_DATO) || (sop == OP_DATOB)); // [RQ14]

   // Write data is latched at slave sync so a late bus change is safe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         snoop_state_reg <= S_IDLE;
         widx_reg <= IDX_FIRST;
         wtag_reg <= '0;
         wdata_reg <= DATA_ZERO;
         tag_we_reg <= 1'b0;
         upper_n_reg <= 1'b1;
         lower_n_reg <= 1'b1;
      end else begin
         tag_we_reg <= 1'b0;
         case (snoop_state_reg)
            S_IDLE: begin
               widx_reg <= sidx;
               wtag_reg <= stag;
               wdata_reg <= sdata_s;
               if (fill_go) begin
                  tag_we_reg <= 1'b1; // [RQ27] [RQ3]
                  upper_n_reg <= 1'b0;
                  lower_n_reg <= 1'b0;
                  snoop_state_reg <= S_WRITING;
               end else if (update_go && (sop == OP_DATOB)) begin
                  upper_n_reg <= !saddr_s[BYTE_SEL_BIT]; // [RQ28]
                  lower_n_reg <= saddr_s[BYTE_SEL_BIT];
                  snoop_state_reg <= S_WRITING;
               end else if (update_go) begin
                  upper_n_reg <= 1'b0; // [RQ4]
                  lower_n_reg <= 1'b0;
                  snoop_state_reg <= S_WRITING;
               end else if (ssync_fall) begin
                  snoop_state_reg <= S_WAIT_END;
               end
            end
            S_WRITING: begin
               if (msync_n_s || !dclo_n_s || !mpwr_n_s) begin
                  upper_n_reg <= 1'b1; // [RQ12] [RQ19]
                  lower_n_reg <= 1'b1;
                  snoop_state_reg <= msync_n_s ? S_IDLE : S_WAIT_END;
               end
            end
            S_WAIT_END: begin
               if (msync_n_s) begin
                  snoop_state_reg <= S_IDLE;
               end
            end
            default: snoop_state_reg <= S_IDLE;
         endcase
      end
   end

   assign sif.wr_idx = widx_reg;
   assign sif.wr_tag = wtag_reg;
   assign sif.wr_data = wdata_reg;
   assign sif.tag_we = tag_we_reg;
   assign sif.upper_byte_wstrobe_n = upper_n_reg;
   assign sif.lower_byte_wstrobe_n = lower_n_reg;

   cache_store u_store (
      .clk_sys(clk_sys),
      .sif(sif)
   );

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_hit_deadline_met: assert property ( // [RQ5]
      (fast_state_reg == F_IDLE && fast_req_go) |->
         ##[1:HIT_WIN] (!cache_hit_n || fast_state_reg == F_RELEASE))
      else $error("hit answer missed the deadline");

   a_write_no_hit: assert property ( // [RQ13]
      (fast_state_reg == F_IDLE && !lookup_n_s && !fast_is_read) |=>
         cache_hit_n [*3])
      else $error("hit raised on a write");

   a_hit_needs_match: assert property ( // [RQ24]
      $fell(cache_hit_n) |->
         $past(sif.rd_valid_a && sif.rd_tag_a == ftag_reg))
      else $error("hit without valid tag match");

   a_ready_after_ok: assert property ( // [RQ7]
      (fast_state_reg == F_WAIT_OK && ok_s && !lookup_n_s) |=>
         (!fast_data_ready_n && fast_rdata == $past(sif.rd_data_a)))
      else $error("data ready not given after control ok");

   a_ready_drop: assert property ( // [RQ9]
      (fast_state_reg == F_SEND && !ok_s) |=>
         (fast_data_ready_n && cache_hit_n))
      else $error("data ready held after control ok fell");

   a_fill_start: assert property ( // [RQ11]
      (snoop_state_reg == S_IDLE && fill_go) |=>
         (!upper_n_reg && !lower_n_reg && tag_we_reg))
      else $error("fill did not start on slave sync");

   a_write_end_msync: assert property ( // [RQ12]
      (snoop_state_reg == S_WRITING && msync_n_s) |=>
         (upper_n_reg && lower_n_reg))
      else $error("array write outlived master sync");

   a_supply_guard: assert property ( // [RQ19]
      !dclo_n_s |=> (upper_n_reg && lower_n_reg && !tag_we_reg))
      else $error("array written during supply low");

   a_byte_lane_sel: assert property ( // [RQ28]
      (snoop_state_reg == S_IDLE && update_go && sop == OP_DATOB) |=>
         (upper_n_reg == !$past(saddr_s[BYTE_SEL_BIT]) ##0
          lower_n_reg == $past(saddr_s[BYTE_SEL_BIT])))
      else $error("wrong byte lane on byte write");

   a_sweep_end: assert property ( // [RQ23]
      (sweep_active_reg && !hold_init && sweep_idx_reg == IDX_LAST) |=>
         !sweep_active_reg)
      else $error("sweep did not stop after the last entry");

   c_read_hit: cover property ($fell(fast_data_ready_n));
   c_fill: cover property (fill_go);
   c_write_update: cover property (update_go);
   c_intr_cycle: cover property ($rose(intr_cycle_reg));

endmodule // cache_top

// file: tb/bus_partner.sv
// Bus master and core memory model seen by the snoop port
`timescale 1ns/1ps
module bus_partner (
   input wire logic clk_sys,
   output logic [cache_pkg::ADDR_W-1:0] snoop_addr_n,
   output logic [cache_pkg::DATA_W-1:0] snoop_wdata_n,
   output logic snoop_op_select0_n,
   output logic snoop_op_select1_n,
   output logic snoop_master_sync_n,
   output logic snoop_slave_sync_n,
   output logic bus_owner_busy_n
);
   import cache_pkg::*;

   // Idle bus: strobes high, nobody owns it
   initial begin
      snoop_addr_n = '1;
      snoop_wdata_n = '1;
      snoop_op_select0_n = 1'b1;
      snoop_op_select1_n = 1'b1;
      snoop_master_sync_n = 1'b1;
      snoop_slave_sync_n = 1'b1;
      bus_owner_busy_n = 1'b1;
   end

   // One full bus transfer; a missed read ends up here
   task automatic cycle(input op_e op, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      bus_owner_busy_n <= 1'b0;
      snoop_addr_n <= ~a;
      snoop_op_select0_n <= ~op[0];
      snoop_op_select1_n <= ~op[1];
      snoop_wdata_n <= ~d;
      repeat (4) @(posedge clk_sys);
      snoop_master_sync_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      snoop_slave_sync_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      snoop_master_sync_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      snoop_slave_sync_n <= 1'b1;
      bus_owner_busy_n <= 1'b1;
      // Released lines flip, so stale values cannot pass for held ones
      snoop_addr_n <= a;
      snoop_wdata_n <= d;
      repeat (3) @(posedge clk_sys);
   endtask
endmodule // bus_partner

// file: tb/cache_top_tb.sv
// Self-checking bench for the word cache
`timescale 1ns/1ps
module cache_top_tb;
   import cache_pkg::*;
   logic clk_sys, rst, fast_lookup_n, fast_op_select0_n;
   logic fast_op_select1_n, cpu_control_ok, cache_hit_n;
   logic fast_data_ready_n, init_active, bus_initialize_n, supply_low_n;
   logic [ADDR_W-1:0] fast_addr, snoop_addr_n;
   logic [DATA_W-1:0] fast_rdata, snoop_wdata_n;
   logic s0_n, s1_n, msync_n, ssync_n, busy_n;
   logic select_ack_n, memory_power_low_n;
   int fail_count = 0, num_checks = 0, cycles = 0;
   localparam logic [ADDR_W-1:0] A1 = {8'h5A, 9'h0A3, 1'b0};
   localparam logic [ADDR_W-1:0] A2 = {8'hA5, 9'h0A3, 1'b0};
   localparam logic [ADDR_W-1:0] A3 = {8'h3C, 9'h155, 1'b0};

   cache_top cache_top_i (.clk_sys(clk_sys), .rst(rst),
      .fast_addr(fast_addr), .fast_lookup_n(fast_lookup_n),
      .fast_op_select0_n(fast_op_select0_n),
      .fast_op_select1_n(fast_op_select1_n),
      .cpu_control_ok(cpu_control_ok), .cache_hit_n(cache_hit_n),
      .fast_data_ready_n(fast_data_ready_n), .fast_rdata(fast_rdata),
      .init_active(init_active), .snoop_addr_n(snoop_addr_n),
      .snoop_wdata_n(snoop_wdata_n), .snoop_op_select0_n(s0_n),
      .snoop_op_select1_n(s1_n), .snoop_master_sync_n(msync_n),
      .snoop_slave_sync_n(ssync_n), .bus_initialize_n(bus_initialize_n),
      .supply_low_n(supply_low_n), .memory_power_low_n(memory_power_low_n),
      .select_ack_n(select_ack_n), .bus_owner_busy_n(busy_n));
   bus_partner bus_partner_i (.clk_sys(clk_sys), .snoop_addr_n(snoop_addr_n),
      .snoop_wdata_n(snoop_wdata_n), .snoop_op_select0_n(s0_n),
      .snoop_op_select1_n(s1_n), .snoop_master_sync_n(msync_n),
      .snoop_slave_sync_n(ssync_n), .bus_owner_busy_n(busy_n));

   ////////////////////////////////////////////////////////////////////
   // Clock, and a run limit well above the few thousand cycles needed
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_bit(input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [DATA_W-1:0] exp,
         input logic [DATA_W-1:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t data %h want %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   // Bounded wait on an output; sampled at the falling edge to avoid races
   task automatic wait_out(input int which, input logic v, input int lim);
      int n;
      n = 0;
      while (n < lim && (which == 0 ? cache_hit_n : (which == 1 ?
            fast_data_ready_n : init_active)) !== v) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // Whole fast cycle as the processor runs it
   task automatic fast_rd(input op_e op, input logic [ADDR_W-1:0] a,
         input logic hit, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      fast_addr <= a;
      fast_op_select0_n <= ~op[0];
      fast_op_select1_n <= ~op[1];
      fast_lookup_n <= 1'b0;
      @(negedge clk_sys);
      wait_out(0, 1'b0, 14); // 150 ns is 15 cycles
      chk_bit(~hit, cache_hit_n);
      if (hit) begin
         @(posedge clk_sys);
         cpu_control_ok <= 1'b1;
         @(negedge clk_sys);
         wait_out(1, 1'b0, 10);
         chk_bit(1'b0, fast_data_ready_n);
         chk_word(d, fast_rdata);
         @(posedge clk_sys);
         cpu_control_ok <= 1'b0;
         @(negedge clk_sys);
         wait_out(1, 1'b1, 10);
         chk_bit(1'b1, fast_data_ready_n);
      end
      @(posedge clk_sys);
      fast_lookup_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic wait_sweep();
      @(negedge clk_sys);
      wait_out(2, 1'b0, 1000);
      chk_bit(1'b0, init_active);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_fill_and_hit();
      fast_rd(OP_DATI, A1, 1'b0, 16'h0000);
      bus_partner_i.cycle(OP_DATI, A1, 16'h1234);
      fast_rd(OP_DATI, A1, 1'b1, 16'h1234);
      fast_rd(OP_DATIP, A1 | 18'h00001, 1'b1, 16'h1234);
      fast_rd(OP_DATO, A1, 1'b0, 16'h0000);
      fast_rd(OP_DATOB, A1, 1'b0, 16'h0000);
   endtask
   task automatic t_write_through();
      bus_partner_i.cycle(OP_DATO, A1, 16'hBEEF);
      fast_rd(OP_DATI, A1, 1'b1, 16'hBEEF);
      bus_partner_i.cycle(OP_DATOB, A1 | 18'h00001, 16'h7700);
      fast_rd(OP_DATI, A1, 1'b1, 16'h77EF);
      bus_partner_i.cycle(OP_DATOB, A1, 16'h0042);
      fast_rd(OP_DATI, A1, 1'b1, 16'h7742);
      @(posedge clk_sys);
      supply_low_n <= 1'b0;
      bus_partner_i.cycle(OP_DATO, A1, 16'hDEAD);
      supply_low_n <= 1'b1;
      fast_rd(OP_DATI, A1, 1'b1, 16'h7742);
   endtask
   task automatic t_replace_and_init();
      bus_partner_i.cycle(OP_DATIP, A2, 16'hC0DE);
      fast_rd(OP_DATI, A1, 1'b0, 16'h0000);
      fast_rd(OP_DATI, A2, 1'b1, 16'hC0DE);
      bus_partner_i.cycle(OP_DATO, A1, 16'h5555);
      fast_rd(OP_DATI, A1, 1'b0, 16'h0000);
      fast_rd(OP_DATI, A2, 1'b1, 16'hC0DE);
      @(posedge clk_sys);
      bus_initialize_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus_initialize_n <= 1'b1;
      wait_sweep();
      fast_rd(OP_DATI, A2, 1'b0, 16'h0000);
   endtask
   // Acknowledge marks the next bus cycle only; power-low restarts sweep
   task automatic t_intr_and_power();
      @(posedge clk_sys);
      select_ack_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      select_ack_n <= 1'b1;
      bus_partner_i.cycle(OP_DATI, A3, 16'h0F0F);
      fast_rd(OP_DATI, A3, 1'b0, 16'h0000);
      bus_partner_i.cycle(OP_DATI, A3, 16'h0F0F);
      fast_rd(OP_DATI, A3, 1'b1, 16'h0F0F);
      memory_power_low_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      memory_power_low_n <= 1'b1;
      wait_sweep();
      fast_rd(OP_DATI, A3, 1'b0, 16'h0000);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      fast_addr = ADDR_ZERO;
      fast_lookup_n = 1'b1;
      fast_op_select0_n = 1'b1;
      fast_op_select1_n = 1'b1;
      cpu_control_ok = 1'b0;
      bus_initialize_n = 1'b1;
      supply_low_n = 1'b1;
      select_ack_n = 1'b1;
      memory_power_low_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wait_sweep();
      chk_bit(1'b1, cache_hit_n);
      chk_bit(1'b1, fast_data_ready_n);
      t_fill_and_hit();
      t_write_through();
      t_replace_and_init();
      t_intr_and_power();
      tally_and_finish();
   end
endmodule // cache_top_tb
